/* rtl/pmn_addr_nvm.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmn_defs.svh"

module pmn_addr_nvm
	import pmn_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire pmn_strap_t strap_pins,
	input  wire logic       nvm_virgin,
	output logic            scl_out,
	output logic            scl_oe_n,
	output logic            sda_out,
	output logic            sda_oe_n,
	output logic [6:0]      dev_addr,
	output logic            addr_valid,
	output logic            init_done,
	output logic            cfg_busy
);

	// Factory image is fixed logic, so it has no write path at all
	function automatic logic [`PMN_CFG_W-1:0] factory_value(
		input logic [`PMN_IDX_W-1:0] idx);
		factory_value = `PMN_FACTORY_BASE | {11'h000, idx};
	endfunction

	function automatic logic [7:0] tri_decode(input logic [1:0] row,
		input logic [1:0] col);
		logic [6:0] a;
		a = `PMN_TRI_BASE + `PMN_TRI_ROW * {5'h00, row} + {5'h00, col};
		if (row == 2'h3 || col == 2'h3 ||
			(row == `PMN_LVL_HIGH && col == `PMN_LVL_HIGH)) begin
			tri_decode = {1'b0, a};
		end else begin
			tri_decode = {1'b1, a};
		end
	endfunction

	pmn_strap_t  strap_s1;
	pmn_strap_t  strap_s2;
	logic        scl_s1, scl_s2, scl_q;
	logic        sda_s1, sda_s2, sda_q;
	pmn_init_t   init_st;
	logic [2:0]  settle_cnt;
	pmn_bus_st_t state;
	logic [7:0]  sh;
	logic [7:0]  cmd;
	logic [7:0]  lo_byte;
	logic [3:0]  bitcnt;
	logic        rw;
	logic        byte_n;
	logic        cmd_only;
	logic        bus_we;
	logic [`PMN_CFG_W-1:0] bus_wdata;
	logic        sup_go;
	pmn_copy_t   sup_mode;
	logic        busy;
	pmn_copy_t   cp_mode;
	logic [`PMN_CNT_W-1:0] cp_cnt;
	logic [`PMN_CFG_W-1:0] fac_q;
	logic [`PMN_CFG_W-1:0] op_rd;
	logic [`PMN_CFG_W-1:0] usr_rd;
	logic        cp_done;
	logic        cp_start;
	pmn_copy_t   cp_start_mode;
	logic        cp_wr;
	logic [`PMN_IDX_W-1:0] cp_widx;
	logic [`PMN_CFG_W-1:0] cp_wdata;
	logic        op_we, usr_we;
	logic [`PMN_IDX_W-1:0] op_waddr, op_raddr;
	logic [`PMN_CFG_W-1:0] op_wdata;
	logic        bus_start, bus_stop, scl_rise, scl_fall;
	logic [9:0]  res_addr;
	logic [7:0]  tri_res;
	logic [1:0]  high_lvl_eff;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			scl_s1   <= 1'b1;
			scl_s2   <= 1'b1;
			scl_q    <= 1'b1;
			sda_s1   <= 1'b1;
			sda_s2   <= 1'b1;
			sda_q    <= 1'b1;
			strap_s1 <= '0;
			strap_s2 <= '0;
		end else begin
			scl_s1   <= scl_in;
			scl_s2   <= scl_s1;
			scl_q    <= scl_s2;
			sda_s1   <= sda_in;
			sda_s2   <= sda_s1;
			sda_q    <= sda_s2;
			strap_s1 <= strap_pins;
			strap_s2 <= strap_s1;
		end
	end

	assign scl_rise  = scl_s2 & ~scl_q;
	assign scl_fall  = ~scl_s2 & scl_q;
	assign bus_start = scl_s2 & scl_q & sda_q & ~sda_s2;
	assign bus_stop  = scl_s2 & scl_q & ~sda_q & sda_s2;

	assign res_addr = `PMN_IDX_MUL * {5'h00, strap_s2.high_idx}
		+ {5'h00, strap_s2.low_idx};
	assign high_lvl_eff = strap_s2.high_present ? strap_s2.high_lvl
		: `PMN_LVL_OPEN;
	assign tri_res = tri_decode(high_lvl_eff, strap_s2.low_lvl);

	// Address fixed once the straps have settled after reset
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dev_addr   <= 7'h00;
			addr_valid <= 1'b0;
		end else if (init_st == IN_SETTLE &&
			settle_cnt == `PMN_SETTLE_LAST) begin
			if (strap_s2.tri_mode) begin
				dev_addr   <= tri_res[6:0];
				addr_valid <= tri_res[7]
					&& tri_res[6:0] != `PMN_ADDR_PROD;
			end else begin
				dev_addr   <= res_addr[6:0];
				addr_valid <= res_addr < `PMN_ADDR_LIMIT
					&& res_addr[6:0] != `PMN_ADDR_PROD;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			init_st    <= IN_SETTLE;
			settle_cnt <= 3'h0;
			init_done  <= 1'b0;
		end else begin
			unique case (init_st)
			IN_SETTLE: begin
				settle_cnt <= settle_cnt + 3'h1;
				if (settle_cnt == `PMN_SETTLE_LAST) begin
					init_st <= nvm_virgin ? IN_FILL : IN_LOAD;
				end
			end
			IN_FILL: if (cp_done) begin
				init_st <= IN_LOAD;
			end
			IN_LOAD: if (cp_done && cp_mode == CP_USER_OP) begin
				init_st   <= IN_RUN;
				init_done <= 1'b1;
			end
			IN_RUN: init_st <= IN_RUN;
			endcase
		end
	end

	always_comb begin
		cp_start      = 1'b0;
		cp_start_mode = CP_USER_OP;
		if (init_st == IN_SETTLE && settle_cnt == `PMN_SETTLE_LAST) begin
			cp_start      = 1'b1;
			cp_start_mode = nvm_virgin ? CP_FAC_USR : CP_USER_OP;
		end else if (init_st == IN_FILL && cp_done) begin
			cp_start      = 1'b1;
			cp_start_mode = CP_USER_OP;
		end else if (init_st == IN_RUN && sup_go) begin
			cp_start      = 1'b1;
			cp_start_mode = sup_mode;
		end
	end

	assign cp_done = busy && cp_cnt == `PMN_CNT_LAST;

	// Reads lead writes by one cycle because both memories register data
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			busy    <= 1'b0;
			cp_mode <= CP_USER_OP;
			cp_cnt  <= '0;
		end else if (cp_start && (!busy || cp_done)) begin
			busy    <= 1'b1;
			cp_mode <= cp_start_mode;
			cp_cnt  <= '0;
		end else if (cp_done) begin
			busy <= 1'b0;
		end else if (busy) begin
			cp_cnt <= cp_cnt + 6'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		fac_q <= factory_value(cp_cnt[`PMN_IDX_W-1:0]);
	end

	assign cp_wr    = busy && cp_cnt != '0;
	assign cp_widx  = cp_cnt[`PMN_IDX_W-1:0] - 5'h01;
	assign cp_wdata = (cp_mode == CP_USER_OP) ? usr_rd
		: (cp_mode == CP_OP_USER) ? op_rd : fac_q;

	assign op_we    = busy ? cp_wr && (cp_mode == CP_USER_OP
		|| cp_mode == CP_FAC_OP) : bus_we;
	assign op_waddr = busy ? cp_widx : cmd[`PMN_IDX_W-1:0];
	assign op_wdata = busy ? cp_wdata : bus_wdata;
	assign op_raddr = busy ? cp_cnt[`PMN_IDX_W-1:0] : cmd[`PMN_IDX_W-1:0];
	assign usr_we   = cp_wr && (cp_mode == CP_OP_USER
		|| cp_mode == CP_FAC_USR);

	pmn_nvm_ram u_op_ram (
		.sys_clk (sys_clk),
		.we      (op_we),
		.waddr   (op_waddr),
		.wdata   (op_wdata),
		.raddr   (op_raddr),
		.rdata   (op_rd)
	);

	pmn_nvm_ram u_usr_nvm (
		.sys_clk (sys_clk),
		.we      (usr_we),
		.waddr   (cp_widx),
		.wdata   (cp_wdata),
		.raddr   (cp_cnt[`PMN_IDX_W-1:0]),
		.rdata   (usr_rd)
	);

	// Send-byte supervisory commands act at the stop that ends them
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sup_go   <= 1'b0;
			sup_mode <= CP_USER_OP;
		end else begin
			sup_go <= 1'b0;
			if (bus_stop && cmd_only) begin
				unique case (cmd)
				`PMN_CMD_RESTO_DEF: begin
					sup_go   <= 1'b1;
					sup_mode <= CP_FAC_OP;
				end
				`PMN_CMD_STORE_USR: begin
					sup_go   <= 1'b1;
					sup_mode <= CP_OP_USER;
				end
				`PMN_CMD_RESTO_USR: begin
					sup_go   <= 1'b1;
					sup_mode <= CP_USER_OP;
				end
				// Store-default is accepted on the bus but never alters it
				default: sup_go <= 1'b0;
				endcase
			end
		end
	end

	// Stretch only while a copy runs; cfg_busy is registered from busy, so it reports the copy one cycle later
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			scl_oe_n <= 1'b1;
			scl_out  <= 1'b0;
			sda_out  <= 1'b0;
			cfg_busy <= 1'b0;
		end else begin
			scl_oe_n <= !(busy && !scl_s2);
			cfg_busy <= busy;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state     <= ST_IDLE;
			sh        <= 8'h00;
			cmd       <= 8'h00;
			lo_byte   <= 8'h00;
			bitcnt    <= 4'h0;
			rw        <= 1'b0;
			byte_n    <= 1'b0;
			cmd_only  <= 1'b0;
			bus_we    <= 1'b0;
			bus_wdata <= '0;
			sda_oe_n  <= 1'b1;
		end else begin
			bus_we <= 1'b0;
			if (bus_start) begin
				state    <= ST_ADDR;
				bitcnt   <= 4'h0;
				// Pairing restarts per frame so a lone byte cannot skew it
				byte_n   <= 1'b0;
				cmd_only <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (bus_stop) begin
				state    <= ST_IDLE;
				cmd_only <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (scl_rise) begin
				unique case (state)
				ST_ADDR, ST_CMD, ST_WR: begin
					sh     <= {sh[6:0], sda_s2};
					bitcnt <= bitcnt + 4'h1;
				end
				ST_RD_AK: if (sda_s2) begin
					state <= ST_IGNORE;
				end
				ST_IDLE, ST_ADDR_AK, ST_CMD_AK, ST_WR_AK, ST_RD,
				ST_IGNORE: state <= state;
				endcase
			end else if (scl_fall) begin
				unique case (state)
				ST_ADDR: if (bitcnt == 4'h8) begin
					if (sh[7:1] == dev_addr && addr_valid &&
						init_done) begin
						state    <= ST_ADDR_AK;
						rw       <= sh[0];
						sda_oe_n <= 1'b0;
					end else begin
						state <= ST_IGNORE;
					end
				end
				ST_ADDR_AK: begin
					bitcnt <= 4'h0;
					if (rw) begin
						state    <= ST_RD;
						sh       <= op_rd[7:0];
						sda_oe_n <= op_rd[7];
						byte_n   <= 1'b1;
					end else begin
						state    <= ST_CMD;
						sda_oe_n <= 1'b1;
					end
				end
				ST_CMD: if (bitcnt == 4'h8) begin
					cmd      <= sh;
					cmd_only <= 1'b1;
					state    <= ST_CMD_AK;
					sda_oe_n <= 1'b0;
				end
				ST_CMD_AK, ST_WR_AK: begin
					state    <= ST_WR;
					bitcnt   <= 4'h0;
					sda_oe_n <= 1'b1;
				end
				ST_WR: if (bitcnt == 4'h8) begin
					cmd_only <= 1'b0;
					state    <= ST_WR_AK;
					sda_oe_n <= 1'b0;
					byte_n   <= ~byte_n;
					if (!byte_n) begin
						lo_byte <= sh;
					end else begin
						bus_we    <= cmd[7:5] == `PMN_SET_GRP;
						bus_wdata <= {sh, lo_byte};
					end
				end
				ST_RD: if (bitcnt == 4'h7) begin
					state    <= ST_RD_AK;
					sda_oe_n <= 1'b1;
				end else begin
					sh       <= {sh[6:0], 1'b0};
					sda_oe_n <= sh[6];
					bitcnt   <= bitcnt + 4'h1;
				end
				ST_RD_AK: begin
					state    <= ST_RD;
					bitcnt   <= 4'h0;
					sh       <= byte_n ? op_rd[15:8] : op_rd[7:0];
					sda_oe_n <= byte_n ? op_rd[15] : op_rd[7];
					byte_n   <= ~byte_n;
				end
				ST_IDLE, ST_IGNORE: sda_oe_n <= 1'b1;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

/* common/pmn_defs.svh */
`ifndef PMN_DEFS_SVH
`define PMN_DEFS_SVH

`define PMN_CFG_W          16
`define PMN_CFG_N          32
`define PMN_IDX_W          5
`define PMN_CNT_W          6
`define PMN_CNT_LAST       6'h20
`define PMN_CMD_STORE_DEF  8'h11
`define PMN_CMD_RESTO_DEF  8'h12
`define PMN_CMD_STORE_USR  8'h15
`define PMN_CMD_RESTO_USR  8'h16
`define PMN_SET_GRP        3'h1
`define PMN_ADDR_PROD      7'h4b
`define PMN_ADDR_LIMIT     10'h080
`define PMN_IDX_MUL        10'h019
`define PMN_TRI_BASE       7'h20
`define PMN_TRI_ROW        7'h03
`define PMN_LVL_LOW        2'h0
`define PMN_LVL_OPEN       2'h1
`define PMN_LVL_HIGH       2'h2
`define PMN_FACTORY_BASE   16'h0100
`define PMN_SETTLE_LAST    3'h4

`endif

/* common/pmn_pkg.sv */
`include "pmn_defs.svh"

package pmn_pkg;

	typedef struct packed {
		logic       tri_mode;
		logic       high_present;
		logic [4:0] low_idx;
		logic [4:0] high_idx;
		logic [1:0] low_lvl;
		logic [1:0] high_lvl;
	} pmn_strap_t;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_ADDR    = 4'b0001,
		ST_ADDR_AK = 4'b0010,
		ST_CMD     = 4'b0011,
		ST_CMD_AK  = 4'b0100,
		ST_WR      = 4'b0101,
		ST_WR_AK   = 4'b0110,
		ST_RD      = 4'b0111,
		ST_RD_AK   = 4'b1000,
		ST_IGNORE  = 4'b1001
	} pmn_bus_st_t;

	typedef enum logic [1:0] {
		CP_USER_OP = 2'b00,
		CP_FAC_OP  = 2'b01,
		CP_OP_USER = 2'b10,
		CP_FAC_USR = 2'b11
	} pmn_copy_t;

	typedef enum logic [1:0] {
		IN_SETTLE = 2'b00,
		IN_FILL   = 2'b01,
		IN_LOAD   = 2'b10,
		IN_RUN    = 2'b11
	} pmn_init_t;

endpackage

/* rtl/pmn_nvm_ram.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmn_defs.svh"

module pmn_nvm_ram (
	input  wire logic                  sys_clk,
	input  wire logic                  we,
	input  wire logic [`PMN_IDX_W-1:0] waddr,
	input  wire logic [`PMN_CFG_W-1:0] wdata,
	input  wire logic [`PMN_IDX_W-1:0] raddr,
	output logic      [`PMN_CFG_W-1:0] rdata
);

	// No reset on the array: contents survive rstn like a stored area
	logic [`PMN_CFG_W-1:0] mem [`PMN_CFG_N];

	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		rdata <= mem[raddr];
	end

endmodule
`default_nettype wire

/* dv/pmn_chk_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module pmn_chk
	import pmn_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire pmn_strap_t strap_pins,
	input wire logic       nvm_virgin,
	input wire logic       scl_out,
	input wire logic       scl_oe_n,
	input wire logic       sda_out,
	input wire logic       sda_oe_n,
	input wire logic [6:0] dev_addr,
	input wire logic       addr_valid,
	input wire logic       init_done,
	input wire logic       cfg_busy
);
	logic [5:0] blen;
	logic [9:0] rsum;
	logic [6:0] tadr;
	logic [1:0] row;

	always_ff @(posedge sys_clk) begin
		blen <= cfg_busy ? blen + 6'h01 : 6'h00;
	end
	assign rsum = strap_pins.high_idx * 10'h019 + strap_pins.low_idx;
	// Missing high strap pin reads as open
	assign row = strap_pins.high_present ? strap_pins.high_lvl : 2'h1;
	assign tadr = 7'h20 + 7'h03 * {5'h00, row} + {5'h00, strap_pins.low_lvl};

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	res_addr_a: assert property ($rose(init_done) && !strap_pins.tri_mode
		&& addr_valid |-> dev_addr == rsum[6:0]) else $error("bad address");
	res_valid_a: assert property ($rose(init_done) && !strap_pins.tri_mode
		|-> addr_valid == (rsum < 10'h080 && rsum != 10'h04b))
		else $error("bad address valid");
	tri_addr_a: assert property ($rose(init_done) && strap_pins.tri_mode
		&& addr_valid |-> dev_addr == tadr) else $error("bad tri address");
	tri_valid_a: assert property ($rose(init_done) && strap_pins.tri_mode
		|-> addr_valid == (row != 2'h3 && strap_pins.low_lvl != 2'h3
		&& {row, strap_pins.low_lvl} != 4'ha)) else $error("bad tri valid");
	prod_addr_a: assert property (addr_valid |-> dev_addr != 7'h4b)
		else $error("production address used");
	addr_hold_a: assert property (init_done && $past(init_done)
		|-> $stable(dev_addr)) else $error("address changed");
	early_ack_a: assert property (!init_done |-> sda_oe_n)
		else $error("ack before init");
	init_time_a: assert property ($rose(rstn) |-> ##[30:90] init_done)
		else $error("init too slow");
	copy_len_a: assert property ($fell(cfg_busy) && $past(init_done, 36)
		|-> blen == 6'h21) else $error("copy length wrong");
	stretch_a: assert property (!scl_oe_n |-> cfg_busy || $past(cfg_busy))
		else $error("stretch outside copy");

	cover property ($fell(cfg_busy) && init_done);
	cover property ($rose(init_done) && strap_pins.tri_mode);
	cover property (!scl_oe_n);
	cover property (!sda_oe_n && init_done);
endmodule

bind pmn_addr_nvm pmn_chk u_chk (.*);

`default_nettype wire

/* dv/pmn_host.sv */
`timescale 1ns/1ps
`default_nettype none

module pmn_host (
	input  wire logic sys_clk,
	input  wire logic scl_w,
	input  wire logic sda_w,
	output var logic  scl_lo,
	output var logic  sda_lo
);
	localparam int Q = 6;
	// Store pause scaled down but outlasts the copy; restores get none
	localparam int HOLD = 40;

	initial begin
		scl_lo = 1'b0;
		sda_lo = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask
	task automatic sclh();
		int k;
		scl_lo = 1'b0;
		for (k = 0; k < 999 && !scl_w; k++) wt(1);
		wt(Q);
	endtask
	task automatic bx(input logic b, output logic r);
		sda_lo = !b;
		wt(Q);
		sclh();
		r = sda_w;
		scl_lo = 1'b1;
		wt(Q);
	endtask
	task automatic start();
		sda_lo = 1'b0;
		wt(Q);
		sclh();
		sda_lo = 1'b1;
		wt(Q);
		scl_lo = 1'b1;
		wt(Q);
	endtask
	task automatic stop();
		sda_lo = 1'b1;
		wt(Q);
		sclh();
		sda_lo = 1'b0;
		// Short free time lets a frame meet a running copy
		wt(Q);
	endtask
	// Ninth bit: a = level the host leaves on SDA
	task automatic by(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic nk);
		for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
		bx(a, nk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] c,
		input logic two, input logic [15:0] d, output logic nk);
		logic [7:0] q;
		logic n;
		start();
		by({a, 1'b0}, 1'b1, q, nk);
		by(c, 1'b1, q, n);
		nk |= n;
		if (two) begin
			by(d[7:0], 1'b1, q, n);
			nk |= n;
			by(d[15:8], 1'b1, q, n);
			nk |= n;
		end
		stop();
		if (c == 8'h11 || c == 8'h15) begin
			wt(HOLD);
		end
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] c,
		output logic [15:0] d, output logic nk);
		logic n;
		start();
		by({a, 1'b0}, 1'b1, d[7:0], nk);
		by(c, 1'b1, d[7:0], n);
		nk |= n;
		start();
		by({a, 1'b1}, 1'b1, d[7:0], n);
		nk |= n;
		by(8'hff, 1'b0, d[7:0], n);
		by(8'hff, 1'b1, d[15:8], n);
		stop();
	endtask
endmodule

`default_nettype wire

/* dv/tb_pmn_addr_nvm.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_pmn_addr_nvm
	import pmn_pkg::*;
();
	logic       sys_clk = 1'b0;
	logic       rstn = 1'b0;
	logic       nvm_virgin = 1'b1;
	pmn_strap_t strap_pins = '0;
	logic       h_scl, h_sda, scl_out, scl_oe_n, sda_out, sda_oe_n;
	logic       addr_valid, init_done, cfg_busy;
	logic [6:0] dev_addr;
	wire        scl_w, sda_w;
	int         n_fail = 0;
	int         n_checks = 0;
	int         cyc = 0;
	int         n_str = 0;
	int         n_busy = 0;

	assign scl_w = !h_scl && (scl_oe_n || scl_out);
	assign sda_w = !h_sda && (sda_oe_n || sda_out);

	pmn_addr_nvm u_dut (.sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_w),
		.sda_in(sda_w), .strap_pins(strap_pins), .nvm_virgin(nvm_virgin),
		.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .dev_addr(dev_addr), .addr_valid(addr_valid),
		.init_done(init_done), .cfg_busy(cfg_busy));
	pmn_host u_host (.sys_clk(sys_clk), .scl_w(scl_w), .sda_w(sda_w),
		.scl_lo(h_scl), .sda_lo(h_sda));

	always #50 sys_clk = !sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (!scl_oe_n)
			n_str++;
		if (cfg_busy)
			n_busy++;
		if (cyc == 60000) begin
			n_fail++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rst(input pmn_strap_t s, input logic v);
		@(posedge sys_clk);
		#5;
		rstn = 1'b0;
		strap_pins = s;
		nvm_virgin = v;
		repeat (5) @(posedge sys_clk);
		#5 rstn = 1'b1;
		for (int k = 0; k < 200 && init_done !== 1'b1; k++)
			@(posedge sys_clk);
		#5;
	endtask
	function automatic pmn_strap_t rs(input logic [4:0] h, input logic [4:0] l);
		return '{1'b0, 1'b1, l, h, 2'h0, 2'h0};
	endfunction
	task automatic rdc(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] d;
		logic nk;
		u_host.rd(7'h3f, c, d, nk);
		chk({15'h0000, nk}, 16'h0000);
		chk(d, e);
	endtask
	task automatic sb(input logic [7:0] c, input logic two, input logic [15:0] d);
		logic nk;
		u_host.wr(7'h3f, c, two, d, nk);
		chk({15'h0000, nk}, 16'h0000);
	endtask

	task automatic t_rw();
		logic [15:0] d;
		logic nk;
		int m;
		rst(rs(5'h02, 5'h0d), 1'b1);
		rdc(8'h21, 16'h0101);
		rdc(8'h3f, 16'h011f);
		u_host.rd(7'h3e, 8'h21, d, nk);
		chk({15'h0000, nk}, 16'h0001);
		sb(8'h21, 1'b1, 16'habcd);
		sb(8'h41, 1'b1, 16'h5555);
		rdc(8'h21, 16'habcd);
		m = n_busy;
		sb(8'h15, 1'b0, 16'h0000);
		chk(16'(n_busy - m), 16'h0021);
		sb(8'h21, 1'b1, 16'h1234);
		sb(8'h16, 1'b0, 16'h0000);
		rdc(8'h21, 16'habcd);
		sb(8'h11, 1'b0, 16'h0000);
		sb(8'h12, 1'b0, 16'h0000);
		rdc(8'h21, 16'h0101);
		m = n_str;
		sb(8'h16, 1'b0, 16'h0000);
		rdc(8'h21, 16'habcd);
		chk({15'h0000, n_str > m}, 16'h0001);
		$display("t_rw done");
	endtask
	task automatic t_keep();
		rst(rs(5'h02, 5'h0d), 1'b0);
		rdc(8'h21, 16'habcd);
		strap_pins = rs(5'h01, 5'h01);
		repeat (20) @(posedge sys_clk);
		chk({9'h000, dev_addr}, 16'h003f);
		$display("t_keep done");
	endtask
	task automatic t_addr();
		logic [4:0] hi[4] = '{5'h04, 5'h00, 5'h05, 5'h03};
		logic [4:0] lo[4] = '{5'h18, 5'h05, 5'h03, 5'h00};
		logic [15:0] d;
		logic nk;
		int e;
		for (int i = 0; i < 4; i++) begin
			rst(rs(hi[i], lo[i]), 1'b0);
			e = 25 * hi[i] + lo[i];
			chk({15'h0000, addr_valid}, 16'(e < 128 && e != 75));
			if (e < 128 && e != 75)
				chk({9'h000, dev_addr}, 16'(e));
		end
		u_host.rd(7'h4b, 8'h21, d, nk);
		chk({15'h0000, nk}, 16'h0001);
		for (int p = 0; p < 2; p++)
			for (int h = 0; h < 3; h++)
				for (int l = 0; l < 3; l++) begin
					rst('{1'b1, p[0], 5'h00, 5'h00, l[1:0], h[1:0]}, 1'b0);
					e = (p == 1) ? 3 * h : 3;
					chk({15'h0000, addr_valid}, 16'(e + l != 8));
					if (e + l != 8)
						chk({9'h000, dev_addr}, 16'(32 + e + l));
				end
		$display("t_addr done");
	endtask

	initial begin
		t_rw();
		t_keep();
		t_addr();
		results();
	end
endmodule

`default_nettype wire
